/* File: usart_cfg_defines.svh */
// register offsets, field positions, reset values and timing counts for the usart configuration block
`ifndef USART_CFG_DEFINES_SVH
`define USART_CFG_DEFINES_SVH
`define OFS_FRAME_CONTROL_B    12'h000
`define OFS_FRAME_CONTROL_C    12'h004
`define OFS_BAUD_DIVISOR_LOW   12'h008
`define OFS_BAUD_DIVISOR_HIGH  12'h00C
`define OFS_FRAME_CONTROL_A    12'h010
`define OFS_STATUS             12'h014
`define FCB_CHAR_SIZE_MSB      2
`define FCA_DOUBLE_SPEED       1
`define FCC_MODE_MSB           7
`define FCC_MODE_LSB           6
`define FCC_SIZE_MSB           2
`define FCC_SIZE_LSB           1
`define FCC_POLARITY           0
`define RST_FRAME_CONTROL_B    8'h00
`define RST_FRAME_CONTROL_C    8'h06
`define RST_FRAME_CONTROL_A    8'h00
`define RST_BAUD_DIVISOR       12'h000
`define OVERSAMPLE_NORMAL      5'h10
`define OVERSAMPLE_DOUBLE      5'h08
`define OVERSAMPLE_SYNC        5'h02
`endif

/* File: usart_cfg_pkg.sv */
// types shared by the usart configuration block
package usart_cfg_pkg;
  typedef enum logic [3:0] {
    MODE_ASYNC    = 4'b0001,
    MODE_SYNC     = 4'b0010,
    MODE_RESERVED = 4'b0100,
    MODE_SPI      = 4'b1000
  } op_mode_e;
endpackage : usart_cfg_pkg

/* File: usart_frame_and_baud_config.sv */
// usart frame format, clock polarity and baud divisor configuration with apb access
// What this block does
// R1 - three-bit size code gives 5,6,7,8 or 9 data bits; 100-110 reserved
// R2 - sync polarity 0: transmit changes on rising, receive samples falling; 1 swaps
// R3 - software keeps polarity bit zero in asynchronous mode
// R4 - 12-bit baud divisor: high register four msbs, low register eight lsbs
// R5 - software writes zeros to reserved top bits of the high register
// R6 - writing the low byte reloads the prescaler at once with the full divisor
// R7 - software avoids changing the divisor during a frame; frames may corrupt
// R8 - divisor zero gives the maximum bit rate with no divider error
// R9 - software picks divisors within half a percent of the target rate
// R10 - double speed divides by eight instead of sixteen, async only
// R11 - two-bit mode field: async, sync, reserved, spi master
// R12 - async bit rate is clock over sixteen or eight times divisor plus one
//
// Added by the designer: the address map and the APB interface to the registers.
`include "usart_cfg_defines.svh"
module usart_frame_and_baud_config #(
  parameter int DIV_W = 12
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [3:0]       data_bits,
  output logic             size_reserved,
  output logic [3:0]       operating_mode,
  output logic             bit_tick,
  output logic             sample_tick,
  output logic             sync_clock_pin,
  output logic             sync_tx_change,
  output logic             sync_rx_sample
);
  logic [7:0]       frame_control_b_ff;
  logic [7:0]       frame_control_c_ff;
  logic [7:0]       frame_control_a_ff;
  logic [DIV_W-1:0] baud_divisor_value_ff;
  logic [DIV_W-1:0] presc_cnt_ff;
  logic [4:0]       over_cnt_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic [3:0]       data_bits_ff;
  logic             size_reserved_ff;
  logic [3:0]       mode_ff;
  logic             bit_tick_ff;
  logic             sample_tick_ff;
  logic             xck_ff;
  logic             tx_change_ff;
  logic             rx_sample_ff;

  wire logic access_w = psel & penable & pready_ff;
  wire logic setup_w  = psel & ~penable;
  wire logic hit_b    = paddr == `OFS_FRAME_CONTROL_B;
  wire logic hit_c    = paddr == `OFS_FRAME_CONTROL_C;
  wire logic hit_lo   = paddr == `OFS_BAUD_DIVISOR_LOW;
  wire logic hit_hi   = paddr == `OFS_BAUD_DIVISOR_HIGH;
  wire logic hit_a    = paddr == `OFS_FRAME_CONTROL_A;
  wire logic hit_st   = paddr == `OFS_STATUS;
  wire logic mapped_w = hit_b | hit_c | hit_lo | hit_hi | hit_a | hit_st;
  wire logic wr_w     = access_w & pwrite & mapped_w;
  wire logic wr_lo_w  = wr_w & hit_lo;

  wire logic [2:0] size_code_w = {frame_control_b_ff[`FCB_CHAR_SIZE_MSB],
                                  frame_control_c_ff[`FCC_SIZE_MSB:`FCC_SIZE_LSB]};
  wire logic [1:0] mode_sel_w  = frame_control_c_ff[`FCC_MODE_MSB:`FCC_MODE_LSB];
  wire logic       polarity_w  = frame_control_c_ff[`FCC_POLARITY];
  wire logic       dbl_w       = frame_control_a_ff[`FCA_DOUBLE_SPEED];

  // R1 size decode
  logic [3:0] nxt_data_bits;
  logic       nxt_size_reserved;
  always_comb begin
    nxt_size_reserved = 1'b0;
    unique case (size_code_w)
      3'b000: nxt_data_bits = 4'h5;
      3'b001: nxt_data_bits = 4'h6;
      3'b010: nxt_data_bits = 4'h7;
      3'b011: nxt_data_bits = 4'h8;
      3'b111: nxt_data_bits = 4'h9;
      default: begin
        nxt_data_bits     = 4'h8;
        nxt_size_reserved = 1'b1;
      end
    endcase
  end

  // R11 mode decode
  usart_cfg_pkg::op_mode_e nxt_mode;
  always_comb begin
    unique case (mode_sel_w)
      2'b00: nxt_mode = usart_cfg_pkg::MODE_ASYNC;
      2'b01: nxt_mode = usart_cfg_pkg::MODE_SYNC;
      2'b10: nxt_mode = usart_cfg_pkg::MODE_RESERVED;
      2'b11: nxt_mode = usart_cfg_pkg::MODE_SPI;
    endcase
  end
  wire logic is_async_w = nxt_mode == usart_cfg_pkg::MODE_ASYNC;
  wire logic is_sync_w  = nxt_mode == usart_cfg_pkg::MODE_SYNC;
  wire logic is_spi_w   = nxt_mode == usart_cfg_pkg::MODE_SPI;

  // R10 oversampling, double speed only counts in async
  wire logic [4:0] over_top_w = is_async_w ? (dbl_w ? `OVERSAMPLE_DOUBLE : `OVERSAMPLE_NORMAL)
                                           : `OVERSAMPLE_SYNC;
  // R4 divisor assembly
  wire logic [DIV_W-1:0] nxt_divisor = hit_lo ? {baud_divisor_value_ff[DIV_W-1:8], pwdata[7:0]}
                                              : {pwdata[DIV_W-9:0], baud_divisor_value_ff[7:0]};
  // R8 zero divisor ticks every clock, exact rate
  wire logic presc_tick_w = presc_cnt_ff == '0;
  // compare with >= so a mode change that shrinks the top value does not run the counter to wrap
  wire logic over_end_w   = presc_tick_w & (over_cnt_ff >= over_top_w - 5'h01);
  wire logic over_half_w  = presc_tick_w & (over_cnt_ff == (over_top_w >> 1) - 5'h01);
  wire logic clk_active_w = is_sync_w | is_spi_w;

  logic [31:0] nxt_prdata;
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_b)  nxt_prdata = {24'h00_0000, frame_control_b_ff};
    if (hit_c)  nxt_prdata = {24'h00_0000, frame_control_c_ff};
    if (hit_a)  nxt_prdata = {24'h00_0000, frame_control_a_ff};
    if (hit_lo) nxt_prdata = {24'h00_0000, baud_divisor_value_ff[7:0]};
    // R5 reserved top bits read as zero
    if (hit_hi) nxt_prdata = {28'h000_0000, baud_divisor_value_ff[DIV_W-1:8]};
    if (hit_st) nxt_prdata = {18'h0_0000, xck_ff, size_reserved_ff, mode_ff, data_bits_ff,
                              presc_tick_w, over_cnt_ff[2:0]};
  end

  // apb: no wait state, answer in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup_w;
    end
  end

  // unmapped offsets answer with an error and leave every register alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= setup_w & ~mapped_w;
    end
  end

  // read data is latched at setup so it stands for the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_w & ~pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_control_b_ff <= `RST_FRAME_CONTROL_B;
    end else if (wr_w & hit_b) begin
      frame_control_b_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_control_c_ff <= `RST_FRAME_CONTROL_C;
    end else if (wr_w & hit_c) begin
      frame_control_c_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_control_a_ff <= `RST_FRAME_CONTROL_A;
    end else if (wr_w & hit_a) begin
      frame_control_a_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_divisor_value_ff <= `RST_BAUD_DIVISOR;
    end else if (wr_w & (hit_lo | hit_hi)) begin
      baud_divisor_value_ff <= nxt_divisor;
    end
  end

  // R6 low write reloads prescaler with full new value
  // R12 prescaler divides by divisor plus one
  logic [DIV_W-1:0] nxt_presc;
  logic [4:0]       nxt_over;
  always_comb begin
    nxt_presc = presc_cnt_ff - {{(DIV_W-1){1'b0}}, 1'b1};
    nxt_over  = over_cnt_ff;
    if (presc_tick_w) begin
      nxt_presc = baud_divisor_value_ff;
      nxt_over  = over_end_w ? 5'h00 : over_cnt_ff + 5'h01;
    end
    if (wr_lo_w) begin
      nxt_presc = nxt_divisor;
      nxt_over  = 5'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_ff <= `RST_BAUD_DIVISOR;
    end else begin
      presc_cnt_ff <= nxt_presc;
    end
  end

  // oversample position; a frame in flight is not protected from a reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_cnt_ff <= 5'h00;
    end else begin
      over_cnt_ff <= nxt_over;
    end
  end

  // R2 polarity picks which clock edge changes and which samples
  wire logic rise_w = over_end_w & clk_active_w & ~xck_ff;
  wire logic fall_w = over_end_w & clk_active_w & xck_ff;

  // decoded fields are registered so every output leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_bits_ff     <= 4'h8;
      size_reserved_ff <= 1'b0;
    end else begin
      data_bits_ff     <= nxt_data_bits;
      size_reserved_ff <= nxt_size_reserved;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 4'b0001;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // a reload restarts the count, so the tick of the old count is dropped
  wire logic nxt_bit_tick    = over_end_w & ~wr_lo_w;
  wire logic nxt_sample_tick = over_half_w & is_async_w & ~wr_lo_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_tick_ff <= 1'b0;
    end else begin
      bit_tick_ff <= nxt_bit_tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_tick_ff <= 1'b0;
    end else begin
      sample_tick_ff <= nxt_sample_tick;
    end
  end

  // outside the clocked modes the pin rests at the polarity level
  wire logic nxt_xck       = clk_active_w ? (xck_ff ^ over_end_w) : polarity_w;
  wire logic nxt_tx_change = is_sync_w & (polarity_w ? fall_w : rise_w);
  wire logic nxt_rx_sample = is_sync_w & (polarity_w ? rise_w : fall_w);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xck_ff <= 1'b0;
    end else begin
      xck_ff <= nxt_xck;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_change_ff <= 1'b0;
      rx_sample_ff <= 1'b0;
    end else begin
      tx_change_ff <= nxt_tx_change;
      rx_sample_ff <= nxt_rx_sample;
    end
  end

  assign data_bits      = data_bits_ff;
  assign size_reserved  = size_reserved_ff;
  assign operating_mode = mode_ff;
  assign bit_tick       = bit_tick_ff;
  assign sample_tick    = sample_tick_ff;
  assign sync_clock_pin = xck_ff;
  assign sync_tx_change = tx_change_ff;
  assign sync_rx_sample = rx_sample_ff;
endmodule : usart_frame_and_baud_config

/* File: usart_cfg_props.sv */
// concurrent checks on the usart configuration block ports
module usart_cfg_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [3:0] data_bits,
  input wire logic       size_reserved,
  input wire logic [3:0] operating_mode,
  input wire logic       bit_tick,
  input wire logic       sample_tick,
  input wire logic       sync_clock_pin,
  input wire logic       sync_tx_change,
  input wire logic       sync_rx_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready) else $error("ready held too long");
  slverr_pair_a: assert property (pslverr |-> pready) else $error("error without ready");
  reserved_shows_a: assert property (size_reserved |-> data_bits == 4'h8) else $error("reserved size count");
  bits_legal_a: assert property (!size_reserved |-> data_bits inside {[4'h5:4'h9]}) else $error("bad bits");
  mode_onehot_a: assert property ($onehot(operating_mode)) else $error("mode not one-hot");
  sample_async_a: assert property (sample_tick |-> operating_mode == usart_cfg_pkg::MODE_ASYNC)
    else $error("sample tick outside async");
  sync_edge_act_a: assert property ($changed(sync_clock_pin) && operating_mode == usart_cfg_pkg::MODE_SYNC
    |-> sync_tx_change ^ sync_rx_sample) else $error("no action on clock edge");
  bit_pulse_a: assert property (bit_tick |=> !bit_tick) else $error("bit tick held");
endmodule : usart_cfg_props
bind usart_frame_and_baud_config usart_cfg_props props_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .data_bits, .size_reserved, .operating_mode, .bit_tick, .sample_tick, .sync_clock_pin, .sync_tx_change,
  .sync_rx_sample);

/* File: usart_line_partner.sv */
// far-side partner model: times the synchronous clock it receives
module usart_line_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sync_clock_pin,
  output int        xck_period
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cyc_ff;
  int   last_ff;
  logic prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= 0;
      last_ff <= 0;
      prev_ff <= 1'b0;
      xck_period <= 0;
    end else begin
      cyc_ff <= cyc_ff + 1;
      prev_ff <= sync_clock_pin;
      if (sync_clock_pin && !prev_ff) begin
        last_ff <= cyc_ff;
        xck_period <= cyc_ff - last_ff;
      end
    end
  end
endmodule : usart_line_partner

/* File: test_usart_frame_and_baud_config.sv */
// self-checking bench for the usart frame and baud configuration block
`include "usart_cfg_defines.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module test_usart_frame_and_baud_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed = 32'h0000_0055;
  logic        pready, pslverr, err, bit_tick, sample_tick, sync_clock_pin, sync_tx_change, sync_rx_sample;
  logic        size_reserved;
  logic [3:0]  data_bits, operating_mode;
  int          n_fail = 0, checks = 0, xck_period, fst, per, d, dv, lim, hlf, ntx, nrx;
  int          exp_bits[8] = '{5, 6, 7, 8, 8, 8, 8, 9};
  always #2.5 pclk = ~pclk;
  usart_frame_and_baud_config dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .data_bits, .size_reserved, .operating_mode, .bit_tick, .sample_tick, .sync_clock_pin,
    .sync_tx_change, .sync_rx_sample);
  usart_line_partner partner_u (.pclk, .presetn, .sync_clock_pin, .xck_period);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic test_done;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin n_fail++; test_done(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask : settle
  // cycles to the first bit tick, then between two ticks
  task automatic gap;
    fst = 0;
    while (bit_tick !== 1'b1 && fst < 6000) begin @(negedge pclk); fst++; end
    per = 0;
    do begin @(negedge pclk); per++; end while (bit_tick !== 1'b1 && per < 300);
    if (per >= 300) begin n_fail++; test_done(); end
    hlf = 0;
    do begin @(negedge pclk); hlf++; end while (sample_tick !== 1'b1 && hlf < 300);
  endtask : gap
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_FRAME_CONTROL_C, 32'h0000_0000);
    `CHK(rd[7:0], `RST_FRAME_CONTROL_C)
    `CHK(operating_mode, usart_cfg_pkg::MODE_ASYNC)
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `OFS_FRAME_CONTROL_B, {29'h0, c[2], 2'b00});
      apb(1'b1, `OFS_FRAME_CONTROL_C, {29'h0, c[1:0], 1'b0});
      settle;
      `CHK(data_bits, 4'(exp_bits[c]))
      `CHK(size_reserved, logic'(c > 3 && c < 7))
    end
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `OFS_FRAME_CONTROL_C, {24'h0, m[1:0], 6'h06});
      settle;
      `CHK(operating_mode, 4'(1 << m))
    end
    // small divisors keep the bench short; the rate error is not judged here
    d = 1 + int'(xs() % 32'h0000_0003);
    // reserved top bits of the high register written as zero
    apb(1'b1, `OFS_BAUD_DIVISOR_HIGH, 32'h0000_00F1 & 32'h0000_000F);
    apb(1'b1, `OFS_BAUD_DIVISOR_LOW, 32'h0000_0020);
    apb(1'b0, `OFS_BAUD_DIVISOR_HIGH, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, `OFS_BAUD_DIVISOR_LOW, 32'h0000_0000);
    `CHK(rd, 32'h0000_0020)
    apb(1'b0, 12'h0F0, 32'h0000_0000);
    `CHK(err, 1'b1)
    // async with polarity bit zero; a large divisor first so the reload shows
    for (int k = 0; k < 4; k++) begin
      dv = k[1] ? d : 0;
      lim = (k[0] ? 8 : 16) * (dv + 1);
      apb(1'b1, `OFS_FRAME_CONTROL_C, 32'h0000_0006);
      // divisor changed only between measurements, never inside a timed bit
      apb(1'b1, `OFS_FRAME_CONTROL_A, {30'h0, k[0], 1'b0});
      apb(1'b1, `OFS_BAUD_DIVISOR_HIGH, 32'h0000_0001);
      apb(1'b1, `OFS_BAUD_DIVISOR_LOW, 32'h0000_0020);
      apb(1'b1, `OFS_BAUD_DIVISOR_HIGH, 32'h0000_0000);
      apb(1'b1, `OFS_BAUD_DIVISOR_LOW, 32'(dv));
      gap;
      `CHK(fst <= lim + 3, 1'b1)
      `CHK(per, lim)
      `CHK(hlf, lim / 2)
    end
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, `OFS_FRAME_CONTROL_C, {24'h0, 8'h46 | 8'(p)});
      ntx = 0;
      nrx = 0;
      for (int t = 0; t < 24 * (d + 1); t++) begin
        @(negedge pclk);
        if (sync_tx_change === 1'b1) `CHK(sync_clock_pin, ~p[0])
        if (sync_rx_sample === 1'b1) `CHK(sync_clock_pin, p[0])
        if (t >= 8 * (d + 1)) begin
          ntx += int'(sync_tx_change === 1'b1);
          nrx += int'(sync_rx_sample === 1'b1);
        end
      end
      `CHK(ntx, 4)
      `CHK(nrx, 4)
      `CHK(xck_period, 4 * (d + 1))
    end
    test_done();
  end
endmodule : test_usart_frame_and_baud_config
